//--- logic/ccs_synth.sv
`timescale 1ns/10ps
// Summary of operation
// - all synthesized clocks derive from the input at 32x line bit clock
// - input clock divided by prescale ratio forms the reference
// - prescale code 00,01,11 gives ratio 1,2,4; code 10 means sleep
// - synth output is reference times integer plus fractional multiplier
// - fraction is numerator plus A over B, all over 65536
// - integer at B0, fraction at B1/B2, A at B3, B at B4
// - synth divided by first ratio, then by second ratio for codec clock
// - post code 000 gives 10/10; codes 001 and 010 give 24/4
// - register clock is synth output divided by register-clock divisor
// - divide field 11 forces 8, 10 forces 4
// - upper bit 0: ratios 10,24,32 give 5,6,4 or 10,12,8
// - lock loss raises the synthesizer error event
module ccs_synth import ccs_pkg::*; (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // clock edges from transceiver and oscillator
  input wire logic i_hclk_tick,
  input wire logic i_vco_tick,
  // register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // synthesizer outputs
  output ccs_clk_s o_clk_en,
  output logic o_ref_tick,
  output logic o_fb_tick,
  output logic o_sleep,
  output logic o_locked,
  output logic o_lock_loss
);
  ccs_cfg_s cfg_r;
  logic [5:0] pre_ratio, pre_cnt_r, fb_cnt_r, fb_target;
  logic [5:0] w_r, y_r, rdiv_r;
  logic [FRAC_W-1:0] frac_acc_r;
  logic [7:0] ab_acc_r;
  logic [8:0] ab_sum;
  logic [FRAC_W:0] frac_sum;
  logic ab_carry, frac_carry_r;
  logic sleep, ref_tick, synth_tick, fb_tick, lost;
  logic signed [3:0] diff_r, diff_nxt;
  logic [2:0] div_in, div_tick;
  logic [5:0] div_ratio [3];
  logic [1:0] pre_code, rdiv_code;
  logic [2:0] post_code;

  assign pre_code = cfg_r.div_sel[PRE_LSB +: 2];
  assign post_code = cfg_r.div_sel[POST_LSB +: 3];
  assign rdiv_code = cfg_r.div_sel[RDIV_LSB +: 2];

  // register writes at the documented offsets
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_r <= '0;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        OFS_INT_MULT: cfg_r.int_mult <= i_reg_wdata[INT_W-1:0];
        OFS_FRAC_HI: cfg_r.frac[15:8] <= i_reg_wdata;
        OFS_FRAC_LO: cfg_r.frac[7:0] <= i_reg_wdata;
        OFS_RATIO_NUM: cfg_r.ratio_num <= i_reg_wdata;
        OFS_RATIO_DEN: cfg_r.ratio_den <= i_reg_wdata;
        OFS_DIV_SEL: cfg_r.div_sel <= i_reg_wdata;
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  // register reads, unused integer bits read zero
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= REG_RST_VAL;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        OFS_INT_MULT: o_reg_rdata <= {2'b00, cfg_r.int_mult};
        OFS_FRAC_HI: o_reg_rdata <= cfg_r.frac[15:8];
        OFS_FRAC_LO: o_reg_rdata <= cfg_r.frac[7:0];
        OFS_RATIO_NUM: o_reg_rdata <= cfg_r.ratio_num;
        OFS_RATIO_DEN: o_reg_rdata <= cfg_r.ratio_den;
        OFS_DIV_SEL: o_reg_rdata <= cfg_r.div_sel;
        default: o_reg_rdata <= UNMAPPED_VAL;
      endcase
    end
  end

  // prescale ratio decode; sleep stops every derived clock
  always_comb begin
    unique case (pre_code)
      PRE_DIV1: pre_ratio = RATIO_1;
      PRE_DIV2: pre_ratio = RATIO_2;
      PRE_DIV4: pre_ratio = RATIO_4;
      PRE_SLEEP: pre_ratio = RATIO_1;
    endcase
  end
  assign sleep = (pre_code == PRE_SLEEP);

  // prescaler turns input clock edges into reference edges
  assign ref_tick = i_hclk_tick && !sleep &&
                    (pre_cnt_r >= pre_ratio - RATIO_1);
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_cnt_r <= '0;
    end else if (sleep) begin
      pre_cnt_r <= '0;
    end else if (i_hclk_tick) begin
      pre_cnt_r <= ref_tick ? '0 : pre_cnt_r + RATIO_1;
    end
  end

  // fractional feedback divider: A/B carry feeds the 16-bit accumulator
  assign synth_tick = i_vco_tick && !sleep;
  assign fb_target = cfg_r.int_mult + {5'd0, frac_carry_r};
  assign fb_tick = synth_tick && (fb_cnt_r >= fb_target - RATIO_1);
  assign ab_sum = {1'b0, ab_acc_r} + {1'b0, cfg_r.ratio_num};
  assign ab_carry = (cfg_r.ratio_den != '0) &&
                    (ab_sum >= {1'b0, cfg_r.ratio_den});
  assign frac_sum = {1'b0, frac_acc_r} + {1'b0, cfg_r.frac} +
                    {{FRAC_W{1'b0}}, ab_carry};

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fb_cnt_r <= '0;
      frac_acc_r <= '0;
      ab_acc_r <= '0;
      frac_carry_r <= 1'b0;
    end else if (synth_tick) begin
      fb_cnt_r <= fb_tick ? '0 : fb_cnt_r + RATIO_1;
      if (fb_tick) begin
        ab_acc_r <= ab_carry ? 8'(ab_sum - {1'b0, cfg_r.ratio_den})
                             : ab_sum[7:0];
        frac_acc_r <= frac_sum[FRAC_W-1:0];
        frac_carry_r <= frac_sum[FRAC_W]; // overflow of 65536 steps
      end
    end
  end

  // post-scale decode; reserved codes leave the setting alone
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      w_r <= RATIO_10;
      y_r <= RATIO_10;
    end else if (post_code == POST_W10) begin
      w_r <= RATIO_10;
      y_r <= RATIO_10;
    end else if (post_code == POST_W24A || post_code == POST_W24B) begin
      w_r <= RATIO_24;
      y_r <= RATIO_4;
    end
  end

  // register-clock divisor selection
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdiv_r <= RATIO_5;
    end else if (rdiv_code == RDIV_FORCE8) begin
      rdiv_r <= RATIO_8;
    end else if (rdiv_code == RDIV_FORCE4) begin
      rdiv_r <= RATIO_4;
    end else if (w_r == RATIO_10) begin
      rdiv_r <= rdiv_code[0] ? RATIO_10 : RATIO_5;
    end else if (w_r == RATIO_24) begin
      rdiv_r <= rdiv_code[0] ? RATIO_12 : RATIO_6;
    end else begin
      rdiv_r <= rdiv_code[0] ? RATIO_8 : RATIO_4;
    end
  end

  // output dividers: compressed-codec, codec-out, register clock
  assign div_in[0] = synth_tick;
  assign div_in[1] = div_tick[0];
  assign div_in[2] = synth_tick;
  assign div_ratio[0] = w_r;
  assign div_ratio[1] = y_r;
  assign div_ratio[2] = rdiv_r;
  for (genvar g = 0; g < 3; g++) begin : g_div
    logic [5:0] cnt_r;
    assign div_tick[g] = div_in[g] && (cnt_r >= div_ratio[g] - RATIO_1);
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        cnt_r <= '0;
      end else if (div_in[g]) begin
        cnt_r <= div_tick[g] ? '0 : cnt_r + RATIO_1;
      end
    end
  end

  // lock monitor counts reference edges against feedback edges
  always_comb begin
    diff_nxt = diff_r;
    if (ref_tick && !fb_tick && diff_r != DIFF_MAX) begin
      diff_nxt = diff_r + 4'sh1;
    end else if (fb_tick && !ref_tick && diff_r != -DIFF_MAX) begin
      diff_nxt = diff_r - 4'sh1;
    end
  end
  assign lost = (diff_nxt > LOCK_TOL) || (diff_nxt < -LOCK_TOL);

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      diff_r <= '0;
      o_locked <= 1'b0;
      o_lock_loss <= 1'b0;
    end else begin
      diff_r <= sleep ? 4'sh0 : diff_nxt;
      o_locked <= !sleep && !lost;
      o_lock_loss <= o_locked && !sleep && lost;
    end
  end

  // registered clock enables and status
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_clk_en <= '0;
      o_ref_tick <= 1'b0;
      o_fb_tick <= 1'b0;
      o_sleep <= 1'b0;
    end else begin
      o_clk_en.synth <= synth_tick;
      o_clk_en.ccodec <= div_tick[0];
      o_clk_en.codec_out <= div_tick[1];
      o_clk_en.regclk <= div_tick[2];
      o_ref_tick <= ref_tick;
      o_fb_tick <= fb_tick;
      o_sleep <= sleep;
    end
  end

  // checks
  ref_src_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    o_ref_tick |-> $past(i_hclk_tick)) else $error("ref without input");
  pre_div2_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (ref_tick && pre_code == PRE_DIV2 && $past(pre_code) == PRE_DIV2 &&
     $past(pre_cnt_r) <= 6'd1) |-> pre_cnt_r == 6'd1)
    else $error("prescale by two broken");
  sleep_quiet_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (sleep && $past(sleep)) |-> !o_clk_en.synth && !o_ref_tick)
    else $error("clock in sleep");
  // a zero fraction and no A/B term must never lengthen the feedback divide
  fb_target_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ($past(fb_tick) && $past(cfg_r.frac) == '0 &&
     $past(cfg_r.ratio_den) == '0) |-> fb_target == cfg_r.int_mult)
    else $error("feedback target off");
  ab_range_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (cfg_r.ratio_den != 0 && $past(cfg_r.ratio_den) == cfg_r.ratio_den
     && $past(ab_acc_r) < cfg_r.ratio_den && $past(cfg_r.ratio_num)
     < cfg_r.ratio_den) |-> ab_acc_r < cfg_r.ratio_den)
    else $error("ratio accumulator overflow");
  post_map_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    $past(post_code) == POST_W10 |-> w_r == 6'd10 && y_r == 6'd10)
    else $error("post code 000 wrong");
  post_keep_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    $past(post_code) > POST_W24B |-> $stable(w_r) && $stable(y_r))
    else $error("reserved code changed ratio");
  codec_chain_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    o_clk_en.codec_out |-> o_clk_en.ccodec && o_clk_en.synth)
    else $error("codec clock not derived");
  regclk_src_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    o_clk_en.regclk |-> o_clk_en.synth) else $error("reg clock source");
  rdiv_force_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    $past(rdiv_code) == RDIV_FORCE8 |-> rdiv_r == 6'd8)
    else $error("forced divisor 8 missing");
  rdiv_follow_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ($past(rdiv_code) == 2'b00 && $past(w_r) == 6'd24) |-> rdiv_r == 6'd6)
    else $error("divisor 6 missing");
  lock_event_a: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    o_lock_loss |-> $past(o_locked) && !o_locked)
    else $error("lock loss without drop");
endmodule

//--- logic/ccs_pkg.sv
package ccs_pkg;
  // register offsets on the processor register port
  localparam logic [7:0] OFS_INT_MULT = 8'hB0;
  localparam logic [7:0] OFS_FRAC_HI = 8'hB1;
  localparam logic [7:0] OFS_FRAC_LO = 8'hB2;
  localparam logic [7:0] OFS_RATIO_NUM = 8'hB3;
  localparam logic [7:0] OFS_RATIO_DEN = 8'hB4;
  localparam logic [7:0] OFS_DIV_SEL = 8'hB5;
  localparam logic [7:0] REG_RST_VAL = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;

  // field positions inside the divider-select register, and widths of the integer and fraction settings
  localparam int PRE_LSB = 0;
  localparam int POST_LSB = 2;
  localparam int RDIV_LSB = 5;
  localparam int INT_W = 6;
  localparam int FRAC_W = 16;

  // prescale codes
  localparam logic [1:0] PRE_DIV1 = 2'h1 - 2'h1;
  localparam logic [1:0] PRE_DIV2 = 2'h1;
  localparam logic [1:0] PRE_SLEEP = 2'h2;
  localparam logic [1:0] PRE_DIV4 = 2'h3;

  // post-scale codes
  localparam logic [2:0] POST_W10 = 3'h0;
  localparam logic [2:0] POST_W24A = 3'h1;
  localparam logic [2:0] POST_W24B = 3'h2;

  // register-clock divide codes
  localparam logic [1:0] RDIV_FORCE4 = 2'h2;
  localparam logic [1:0] RDIV_FORCE8 = 2'h3;

  // divide ratios
  localparam logic [5:0] RATIO_1 = 6'h01;
  localparam logic [5:0] RATIO_2 = 6'h02;
  localparam logic [5:0] RATIO_4 = 6'h04;
  localparam logic [5:0] RATIO_5 = 6'h05;
  localparam logic [5:0] RATIO_6 = 6'h06;
  localparam logic [5:0] RATIO_8 = 6'h08;
  localparam logic [5:0] RATIO_10 = 6'h0A;
  localparam logic [5:0] RATIO_12 = 6'h0C;
  localparam logic [5:0] RATIO_24 = 6'h18;
  localparam logic [5:0] RATIO_32 = 6'h20;

  // lock monitor window, in reference-versus-feedback edges
  localparam logic signed [3:0] LOCK_TOL = 4'sh2;
  localparam logic signed [3:0] DIFF_MAX = 4'sh7;

  // programmed synthesizer settings
  typedef struct packed {
    logic [INT_W-1:0] int_mult;
    logic [FRAC_W-1:0] frac;
    logic [7:0] ratio_num;
    logic [7:0] ratio_den;
    logic [7:0] div_sel;
  } ccs_cfg_s;

  // one-cycle clock enables produced by the block
  typedef struct packed {
    logic synth;
    logic ccodec;
    logic codec_out;
    logic regclk;
  } ccs_clk_s;
endpackage

//--- verif/ccs_hclk_src.sv
`timescale 1ns/10ps
// transceiver and oscillator edge source, steady or sparse
module ccs_hclk_src (
  // clock
  input wire logic i_clk,
  // controls
  input wire logic i_hclk_on,
  input wire logic i_vco_on,
  input wire logic i_slow,
  // edge pulses
  output logic o_hclk_tick = 1'b0,
  output logic o_vco_tick = 1'b0
);
  // sparse mode drops edges at random so the dividers see uneven gaps
  always @(posedge i_clk) begin
    o_hclk_tick <= i_hclk_on && (!i_slow || $urandom % 3 == 0);
    o_vco_tick <= i_vco_on && (!i_slow || $urandom % 2 == 0);
  end
endmodule

//--- verif/ccs_synth_tb.sv
`timescale 1ns/10ps
module ccs_synth_tb;
  import ccs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, v, d;
  logic hclk, vco, ref_t, fb_t, sleep, locked, loss;
  logic hclk_d = 1'b0;
  logic vco_d = 1'b0;
  logic hclk_on = 1'b0;
  logic vco_on = 1'b0;
  logic slow = 1'b0;
  ccs_clk_s en;
  logic [4:0] tgt, base;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int losses = 0;
  int cnt[5], gap[5], pgap[5], nev[5];
  int w_m = 10;
  int y_m = 10;
  int n0, p;
  int posts[5] = '{0, 3, 1, 7, 2};
  int pres[3] = '{0, 1, 3};

  always #5 clk = ~clk;

  ccs_hclk_src ccs_hclk_src_i (.i_clk(clk), .i_hclk_on(hclk_on),
    .i_vco_on(vco_on), .i_slow(slow), .o_hclk_tick(hclk),
    .o_vco_tick(vco));
  ccs_synth ccs_synth_i (.i_core_clk(clk), .i_sys_rst(rst),
    .i_hclk_tick(hclk), .i_vco_tick(vco), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_clk_en(en), .o_ref_tick(ref_t), .o_fb_tick(fb_t), .o_sleep(sleep),
    .o_locked(locked), .o_lock_loss(loss));

  // each output pulse paired with the edges it divides
  assign tgt = {en.regclk, en.codec_out, en.ccodec, fb_t, ref_t};
  assign base = {en.synth, en.ccodec, en.synth, vco_d, hclk_d};

  // gap meter: base edges counted between target pulses
  always @(posedge clk) begin
    int n;
    hclk_d <= hclk;
    vco_d <= vco;
    cyc++;
    if (loss === 1'b1) losses++;
    for (int i = 0; i < 5; i++) begin
      n = cnt[i] + int'(base[i]);
      if (tgt[i] === 1'b1) begin
        pgap[i] = gap[i];
        gap[i] = n;
        cnt[i] = 0;
        nev[i]++;
      end else begin
        cnt[i] = n;
      end
    end
    if (cyc == 60000) begin
      failures++;
      conclude();
    end
  end

  task automatic chk_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic chk_int(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin
      failures++;
      $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk);
    wr <= 1'b1; // one access every other cycle
    addr <= a;
    wdata <= dat;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] dat);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 dat = rdata;
  endtask

  // four fresh target pulses so the last two gaps are clean
  task automatic wait_ev(input int k);
    int t;
    t = 0;
    n0 = nev[k];
    while (nev[k] < n0 + 4 && t < 4000) begin
      @(posedge clk);
      t++;
    end
    if (nev[k] < n0 + 4) begin
      failures++;
      $display("unexpected event count %0d: expected %0d, seen %0d", k,
               n0 + 4, nev[k]);
    end
  endtask

  // register clock divisor from select code and first post-scale ratio
  function automatic int rdiv_m(input int sel, input int w);
    if (sel >= 2) return (sel == 3) ? 8 : 4;
    return ((w == 10) ? 5 : 6) * (sel + 1);
  endfunction

  task automatic conclude();
    $display("checks %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    void'($urandom(28551));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // reset values, then random readback including an unmapped hole
    for (int a = 8'hB0; a <= 8'hB6; a++) begin
      rd_reg(8'(a), v);
      chk_byte("reset value", REG_RST_VAL, v);
      d = 8'($urandom);
      wr_reg(8'(a), d);
      rd_reg(8'(a), v);
      if (a == 8'hB6) d = UNMAPPED_VAL;
      if (a == 8'hB0) d = d & 8'h3F;
      chk_byte("readback", d, v);
    end
    for (int a = 8'hB0; a <= 8'hB4; a++) wr_reg(8'(a), 8'h00);
    wr_reg(OFS_INT_MULT, 8'h01);
    hclk_on <= 1'b1;
    vco_on <= 1'b1;
    slow <= 1'b1;
    // prescale ratios under sparse high-rate edges
    foreach (pres[i]) begin
      wr_reg(OFS_DIV_SEL, 8'(pres[i]));
      wait_ev(0);
      p = (pres[i] == 3) ? 4 : pres[i] + 1;
      chk_int("prescale gap", p, gap[0]);
    end
    // sleep code stops reference, feedback and compressed-codec edges
    wr_reg(OFS_DIV_SEL, 8'h02);
    repeat (4) @(posedge clk);
    p = nev[0] + nev[1] + nev[2];
    repeat (40) @(posedge clk);
    chk_int("sleep edges", p, nev[0] + nev[1] + nev[2]);
    chk_byte("sleep flag", 8'h01, {7'h00, sleep});
    // post-scale codes, reserved ones included, with every divide code
    foreach (posts[i]) begin
      for (int r = 0; r < 4; r++) begin
        wr_reg(OFS_DIV_SEL, {1'b0, 2'(r), 3'(posts[i]), 2'b00});
        if (posts[i] <= 2) w_m = (posts[i] == 0) ? 10 : 24;
        if (posts[i] <= 2) y_m = (posts[i] == 0) ? 10 : 4;
        wait_ev(2);
        chk_int("ccodec gap", w_m, gap[2]);
        wait_ev(3);
        chk_int("codec out gap", y_m, gap[3]);
        wait_ev(4);
        chk_int("regclk gap", rdiv_m(r, w_m), gap[4]);
      end
    end
    // lock with matched edges, then loss when the oscillator stops
    slow <= 1'b0;
    wr_reg(OFS_DIV_SEL, 8'h02);
    wr_reg(OFS_DIV_SEL, 8'h00);
    repeat (20) @(posedge clk);
    chk_byte("locked", 8'h01, {7'h00, locked});
    p = losses;
    vco_on <= 1'b0;
    repeat (20) @(posedge clk);
    chk_int("lock losses", p + 1, losses);
    chk_byte("unlocked", 8'h00, {7'h00, locked});
    // feedback divide: whole multiplier, then a half fraction
    vco_on <= 1'b1;
    wr_reg(OFS_INT_MULT, 8'h03);
    wait_ev(1);
    chk_int("feedback gap", 3, gap[1]);
    wr_reg(OFS_FRAC_HI, 8'h80);
    wait_ev(1);
    chk_int("feedback pair", 7, gap[1] + pgap[1]);
    // settings written first, then a mid-run reset clears the registers
    wr_reg(OFS_DIV_SEL, 8'h19);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(OFS_INT_MULT, v);
    chk_byte("reset value", REG_RST_VAL, v);
    rd_reg(OFS_DIV_SEL, v);
    chk_byte("reset value", REG_RST_VAL, v);
    conclude();
  end
endmodule
